// File: design/tms_consts.svh
`ifndef TMS_CONSTS_SVH
`define TMS_CONSTS_SVH
`define TMS_CLK_NS 100
`define TMS_MODE_SLEEP 3'h0
`define TMS_MODE_STANDBY 3'h1
`define TMS_MODE_SYNTH 3'h2
`define TMS_MODE_TX 3'h3
`define TMS_MODE_RX 3'h4
`define TMS_FEI_BITS 4
`define TMS_TIMEOUT_BITS 16
`define TMS_TEMP_MAX_US 100
`define TMS_TEMP_CYCLES ((`TMS_TEMP_MAX_US * 1000) / `TMS_CLK_NS)
`define TMS_TEMP_CONV_CYCLES 16'h0200
`define TMS_DIGITAL_DELAY_NS 5000
`define TMS_DIGITAL_CYCLES ((`TMS_DIGITAL_DELAY_NS + `TMS_CLK_NS - 1) / `TMS_CLK_NS)
`define TMS_PA_REG_CYCLES 16'h0004
`define TMS_OSC_CYCLES 16'h0020
`define TMS_OFFSET_STEP_HZ 488
`endif

// File: design/tms_pkg.sv
package tms_pkg;
  typedef enum logic [7:0] {
    SEQ_IDLE = 8'h01,
    SEQ_OSC = 8'h02,
    SEQ_SYNTH = 8'h04,
    SEQ_PAREG = 8'h08,
    SEQ_RAMP = 8'h10,
    SEQ_TXRUN = 8'h20,
    SEQ_RX = 8'h40,
    SEQ_DIRECT = 8'h80
  } tms_seq_e;
  typedef logic [15:0] tms_count_t;
endpackage

// File: design/tms_timer.sv
`timescale 1ns/1ps
// loadable down counter; done pulses one cycle when the count runs out
module tms_timer (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic start_in,
  input wire logic stop_in,
  input wire logic [23:0] load_in,
  output logic busy_out,
  output logic done_out
);
  logic [23:0] count;
  logic [23:0] next_count;
  logic busy;
  logic next_busy;
  logic done;
  logic next_done;
  always_comb begin
    next_count = count;
    next_busy = busy;
    next_done = 1'b0;
    if (start_in) begin
      next_count = (load_in == 24'h0) ? 24'h1 : load_in;
      next_busy = 1'b1;
    end else if (stop_in) begin
      next_busy = 1'b0;
    end else if (busy) begin
      if (count == 24'h1) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
      next_count = count - 24'h1;
    end
  end
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      count <= 24'h0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      count <= next_count;
      busy <= next_busy;
      done <= next_done;
    end
  end
  assign busy_out = busy;
  assign done_out = done;
endmodule

// File: design/tms_sequencer.sv
`timescale 1ns/1ps
`include "tms_consts.svh"
// Notes on behaviour
// - signed frequency error stored in step units
// - each error evaluation ends within four bits
// - correction subtracted from carrier setting
// - auto enable corrects at every receive entry
// - otherwise correction starts on host start bit
// - auto correction clears old value if enabled
// - correction phase uses correction filter bandwidth
// - low index adds offset field times 488 Hz
// - temperature only in standby or synthesizer
// - temperature result minus one degree per lsb
// - temperature running clears within 100 us
// - timeout if level flag absent after start
// - timeout after flag plus threshold period
// - mode field selects five basic modes
// - listen enable overrides mode field
// - sequencer disable switches mode directly
// - sleep to transmit via standby and synthesizer
// - regulator, then ramp, then data clock
// - lock pin high once synthesizer locked
// - tx delay 5us plus 1.25 ramp plus half bit; the code also adds 4 regulator cycles before the ramp
module tms_sequencer (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic [2:0] mode_in,
  input wire logic listen_enable_in,
  input wire logic sequencer_disable_in,
  input wire logic [15:0] bit_cycles_in,
  input wire logic [15:0] amp_ramp_time_in,
  input wire logic osc_ready_in,
  input wire logic synth_lock_in,
  input wire logic auto_correction_enable_in,
  input wire logic correction_start_in,
  input wire logic correction_auto_clear_in,
  input wire logic low_index_correction_enable_in,
  input wire logic [7:0] low_index_offset_in,
  input wire logic [15:0] freq_error_sample_in,
  input wire logic [23:0] carrier_setting_in,
  input wire logic [2:0] rx_bandwidth_in,
  input wire logic [2:0] correction_bandwidth_in,
  input wire logic temp_start_in,
  input wire logic [7:0] temp_adc_in,
  input wire logic [7:0] rx_start_timeout_in,
  input wire logic [7:0] threshold_timeout_in,
  input wire logic signal_level_threshold_in,
  output logic [2:0] active_mode_out,
  output logic listen_active_out,
  output logic osc_enable_out,
  output logic synth_enable_out,
  output logic tx_enable_out,
  output logic rx_enable_out,
  output logic amp_regulator_out,
  output logic amp_ramp_out,
  output logic data_clock_enable_out,
  output logic synth_lock_out,
  output logic [15:0] freq_error_result_out,
  output logic [15:0] freq_correction_result_out,
  output logic [23:0] carrier_out,
  output logic [2:0] channel_bandwidth_out,
  output logic correction_busy_out,
  output logic correction_start_clear_out,
  output logic temp_running_out,
  output logic temp_start_clear_out,
  output logic [7:0] temp_value_out,
  output logic timeout_out
);
  ////////////////////////////////////////////////////////////////////////
  // pin inputs pass two flops
  logic [1:0] osc_sync;
  logic [1:0] lock_sync;
  logic [1:0] level_sync;
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      osc_sync <= 2'h0;
      lock_sync <= 2'h0;
      level_sync <= 2'h0;
    end else begin
      osc_sync <= {osc_sync[0], osc_ready_in};
      lock_sync <= {lock_sync[0], synth_lock_in};
      level_sync <= {level_sync[0], signal_level_threshold_in};
    end
  end
  wire osc_ok = osc_sync[1];
  wire locked = lock_sync[1];
  wire level = level_sync[1];

  function automatic logic [23:0] mul24(input logic [15:0] a, input logic [7:0] b);
    logic [23:0] p;
    p = 24'(a) * 24'(b);
    return p;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // mode sequencer
  tms_pkg::tms_seq_e state;
  tms_pkg::tms_seq_e next_state;
  logic [2:0] cur_mode;
  logic [2:0] next_cur_mode;
  logic seq_start;
  logic [23:0] seq_load;
  logic seq_busy;
  logic seq_done;
  wire [2:0] target = mode_in;
  // ramp is weighted 1.25 times; tx delay fixed digital plus half bit
  wire [23:0] ramp_cycles = 24'(amp_ramp_time_in) + 24'(amp_ramp_time_in >> 2);
  wire [23:0] tx_digital = 24'(`TMS_DIGITAL_CYCLES) + 24'(bit_cycles_in >> 1);
  always_comb begin
    next_state = state;
    next_cur_mode = cur_mode;
    seq_start = 1'b0;
    seq_load = 24'h0;
    if (listen_enable_in) begin
      next_state = tms_pkg::SEQ_IDLE;
      next_cur_mode = `TMS_MODE_STANDBY;
    end else if (sequencer_disable_in) begin
      next_state = tms_pkg::SEQ_DIRECT;
      next_cur_mode = target;
    end else begin
      case (state)
        tms_pkg::SEQ_IDLE, tms_pkg::SEQ_DIRECT, tms_pkg::SEQ_RX, tms_pkg::SEQ_TXRUN: begin
          if (target != cur_mode) begin
            if (target == `TMS_MODE_SLEEP || target == `TMS_MODE_STANDBY) begin
              next_cur_mode = target;
              next_state = tms_pkg::SEQ_IDLE;
            end else if (cur_mode == `TMS_MODE_SLEEP) begin
              next_cur_mode = `TMS_MODE_STANDBY;
              next_state = tms_pkg::SEQ_OSC;
            end else begin
              next_cur_mode = `TMS_MODE_SYNTH;
              next_state = tms_pkg::SEQ_SYNTH;
            end
          end
        end
        tms_pkg::SEQ_OSC: begin
          if (osc_ok) begin
            next_cur_mode = `TMS_MODE_SYNTH;
            next_state = tms_pkg::SEQ_SYNTH;
          end
        end
        tms_pkg::SEQ_SYNTH: begin
          if (target == `TMS_MODE_SYNTH) begin
            next_state = tms_pkg::SEQ_IDLE;
          end else if (locked) begin
            if (target == `TMS_MODE_TX) begin
              next_cur_mode = `TMS_MODE_TX;
              next_state = tms_pkg::SEQ_PAREG;
              seq_start = 1'b1;
              seq_load = 24'(`TMS_PA_REG_CYCLES) + tx_digital;
            end else if (target == `TMS_MODE_RX) begin
              next_cur_mode = `TMS_MODE_RX;
              next_state = tms_pkg::SEQ_RX;
            end else begin
              next_state = tms_pkg::SEQ_IDLE;
            end
          end
        end
        tms_pkg::SEQ_PAREG: begin
          if (seq_done) begin
            next_state = tms_pkg::SEQ_RAMP;
            seq_start = 1'b1;
            seq_load = ramp_cycles;
          end
        end
        tms_pkg::SEQ_RAMP: begin
          if (seq_done) begin
            next_state = tms_pkg::SEQ_TXRUN;
          end
        end
        default: begin
          next_state = tms_pkg::SEQ_IDLE;
        end
      endcase
    end
  end
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state <= tms_pkg::SEQ_IDLE;
      cur_mode <= `TMS_MODE_SLEEP;
    end else begin
      state <= next_state;
      cur_mode <= next_cur_mode;
    end
  end
  tms_timer u_seq_timer (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .start_in(seq_start),
    .stop_in(state != tms_pkg::SEQ_PAREG && state != tms_pkg::SEQ_RAMP),
    .load_in(seq_load),
    .busy_out(seq_busy),
    .done_out(seq_done)
  );
  wire in_tx = cur_mode == `TMS_MODE_TX;
  wire in_rx = cur_mode == `TMS_MODE_RX;
  wire direct = state == tms_pkg::SEQ_DIRECT;
  assign active_mode_out = cur_mode;
  assign listen_active_out = listen_enable_in;
  assign osc_enable_out = cur_mode != `TMS_MODE_SLEEP;
  assign synth_enable_out = cur_mode == `TMS_MODE_SYNTH || in_tx || in_rx;
  assign tx_enable_out = in_tx;
  assign rx_enable_out = in_rx;
  assign amp_regulator_out = in_tx && (direct || state != tms_pkg::SEQ_IDLE);
  assign amp_ramp_out = in_tx && (direct || state == tms_pkg::SEQ_RAMP ||
                                  state == tms_pkg::SEQ_TXRUN);
  assign data_clock_enable_out = in_tx && (direct || state == tms_pkg::SEQ_TXRUN);
  assign synth_lock_out = locked;

  ////////////////////////////////////////////////////////////////////////
  // frequency error measurement and correction
  logic corr_busy;
  logic next_corr_busy;
  logic [15:0] freq_error_measure;
  logic [15:0] next_fei;
  logic [15:0] corr;
  logic [15:0] next_corr;
  logic [23:0] carrier;
  logic [23:0] next_carrier;
  logic [23:0] corr_cnt;
  logic [23:0] next_corr_cnt;
  logic rx_prev;
  logic corr_clear;
  // offset in synthesizer steps; the step figure is carried on the offset input
  wire [15:0] low_offset = 16'(low_index_offset_in);
  wire auto_go = auto_correction_enable_in && in_rx && !rx_prev;
  wire manual_go = !auto_correction_enable_in && correction_start_in;
  always_comb begin
    next_corr_busy = corr_busy;
    next_fei = freq_error_measure;
    next_corr = corr;
    next_carrier = carrier;
    next_corr_cnt = corr_cnt;
    corr_clear = 1'b0;
    if (!corr_busy && (auto_go || manual_go)) begin
      next_corr_busy = 1'b1;
      corr_clear = manual_go;
      next_corr_cnt = mul24(bit_cycles_in, 8'(`TMS_FEI_BITS));
      if (auto_go && correction_auto_clear_in) begin
        next_carrier = carrier + 24'($signed(corr));
        next_corr = 16'h0;
      end
    end else if (corr_busy) begin
      if (corr_cnt <= 24'h1) begin
        next_corr_busy = 1'b0;
        next_fei = freq_error_sample_in;
        next_corr = low_index_correction_enable_in ?
                    freq_error_sample_in + low_offset : freq_error_sample_in;
        next_carrier = carrier - 24'($signed(next_corr));
      end else begin
        next_corr_cnt = corr_cnt - 24'h1;
      end
    end
  end
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      corr_busy <= 1'b0;
      freq_error_measure <= 16'h0;
      corr <= 16'h0;
      carrier <= 24'h0;
      corr_cnt <= 24'h0;
      rx_prev <= 1'b0;
    end else begin
      corr_busy <= next_corr_busy;
      freq_error_measure <= next_fei;
      corr <= next_corr;
      carrier <= next_carrier;
      corr_cnt <= next_corr_cnt;
      rx_prev <= in_rx;
    end
  end
  wire [23:0] base_carrier = carrier_setting_in + carrier;
  assign carrier_out = base_carrier;
  assign freq_error_result_out = freq_error_measure;
  assign freq_correction_result_out = corr;
  assign correction_busy_out = corr_busy;
  assign correction_start_clear_out = corr_clear;
  assign channel_bandwidth_out = corr_busy ? correction_bandwidth_in : rx_bandwidth_in;

  ////////////////////////////////////////////////////////////////////////
  // temperature; ends well inside the documented bound
  logic temp_go;
  logic temp_busy;
  logic temp_done;
  logic [7:0] temp_val;
  logic [7:0] next_temp_val;
  wire temp_mode_ok = cur_mode == `TMS_MODE_STANDBY || cur_mode == `TMS_MODE_SYNTH;
  // running covers the store cycle, so the value is valid once the flag clears
  wire temp_active = temp_busy || temp_done;
  assign temp_go = temp_start_in && temp_mode_ok && !temp_active;
  tms_timer u_temp_timer (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .start_in(temp_go),
    .stop_in(1'b0),
    .load_in(24'(`TMS_TEMP_CONV_CYCLES)),
    .busy_out(temp_busy),
    .done_out(temp_done)
  );
  always_comb begin
    next_temp_val = temp_val;
    if (temp_done) begin
      next_temp_val = 8'hff - temp_adc_in;
    end
  end
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      temp_val <= 8'h0;
    end else begin
      temp_val <= next_temp_val;
    end
  end
  assign temp_running_out = temp_active;
  assign temp_start_clear_out = temp_go;
  assign temp_value_out = temp_val;

  ////////////////////////////////////////////////////////////////////////
  // receive timeouts
  logic level_prev;
  logic to_start;
  logic [23:0] to_load;
  logic to_done;
  logic to_busy;
  wire [15:0] unit16 = 16'(bit_cycles_in << 4);
  always_comb begin
    to_start = 1'b0;
    to_load = 24'h0;
    if (in_rx && !rx_prev && rx_start_timeout_in != 8'h0) begin
      to_start = 1'b1;
      to_load = mul24(unit16, rx_start_timeout_in);
    end else if (in_rx && level && !level_prev) begin
      to_start = threshold_timeout_in != 8'h0;
      to_load = mul24(unit16, threshold_timeout_in);
    end
  end
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      level_prev <= 1'b0;
    end else begin
      level_prev <= level;
    end
  end
  tms_timer u_to_timer (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .start_in(to_start),
    .stop_in(!in_rx || (level && !level_prev && threshold_timeout_in == 8'h0)),
    .load_in(to_load),
    .busy_out(to_busy),
    .done_out(to_done)
  );
  assign timeout_out = to_done && in_rx;

  ////////////////////////////////////////////////////////////////////////
  chk_temp_bound: assert property (@(posedge clock_in) disable iff (reset_in)
    temp_go |=> temp_busy [*8] ##[1:1000] !temp_busy) else $error("temperature overrun");
  chk_bw_select: assert property (@(posedge clock_in) disable iff (reset_in)
    corr_busy |-> channel_bandwidth_out == correction_bandwidth_in) else $error("bandwidth");
  chk_listen: assert property (@(posedge clock_in) disable iff (reset_in)
    listen_enable_in |=> state == tms_pkg::SEQ_IDLE) else $error("listen override");
  chk_direct_mode: assert property (@(posedge clock_in) disable iff (reset_in)
    sequencer_disable_in && !listen_enable_in |=> cur_mode == $past(mode_in))
    else $error("direct mode");
  sequence s_ramp_phase;
    state == tms_pkg::SEQ_RAMP;
  endsequence
  chk_ramp_phase: assert property (@(posedge clock_in) disable iff (reset_in)
    s_ramp_phase |-> amp_regulator_out && amp_ramp_out && !data_clock_enable_out)
    else $error("ramp phase outputs");
  chk_data_clock_out_order: assert property (@(posedge clock_in) disable iff (reset_in)
    $rose(data_clock_enable_out) && !direct |-> $past(amp_ramp_out)) else $error("data_clock_out early");
  chk_lock_gate: assert property (@(posedge clock_in) disable iff (reset_in)
    state == tms_pkg::SEQ_SYNTH && next_state == tms_pkg::SEQ_PAREG |-> locked)
    else $error("tx before lock");
  chk_temp_mode: assert property (@(posedge clock_in) disable iff (reset_in)
    temp_go |-> temp_mode_ok) else $error("temp in wrong mode");
  chk_fei_store: assert property (@(posedge clock_in) disable iff (reset_in)
    $fell(corr_busy) |-> freq_error_measure == $past(freq_error_sample_in)) else $error("fei not stored");
  chk_lock_pin: assert property (@(posedge clock_in) disable iff (reset_in)
    lock_sync[1] |-> synth_lock_out) else $error("lock pin");
endmodule

// File: tb/tms_radio_model.sv
`timescale 1ns/1ps
// stands in for the crystal, the pll and the rf front end around the sequencer
module tms_radio_model #(
  parameter int OSC_WAIT = 20,
  parameter int LOCK_WAIT = 30
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic osc_enable_in,
  input wire logic synth_enable_in,
  input wire logic carrier_on_in,
  output logic osc_ready_out,
  output logic synth_lock_out,
  output logic signal_level_out
);
  int osc_count;
  int lock_count;
  ////////////////////////////////////////
  always_ff @(posedge clock_in) begin
    if (reset_in || !osc_enable_in) begin
      osc_count <= 0;
    end else if (osc_count < OSC_WAIT) begin
      osc_count <= osc_count + 1;
    end
    // the pll cannot settle before the crystal does
    if (reset_in || !synth_enable_in || !osc_ready_out) begin
      lock_count <= 0;
    end else if (lock_count < LOCK_WAIT) begin
      lock_count <= lock_count + 1;
    end
  end
  // a disabled block drops its status at once, no kinder than silicon
  assign osc_ready_out = osc_count == OSC_WAIT;
  assign synth_lock_out = lock_count == LOCK_WAIT;
  assign signal_level_out = carrier_on_in && synth_lock_out;
endmodule

// File: tb/transceiver_mode_sequencer_test.sv
`timescale 1ns/1ps
`include "tms_consts.svh"
module transceiver_mode_sequencer_test;
  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  logic [2:0] mode_in, rx_bandwidth_in, correction_bandwidth_in;
  logic [2:0] active_mode_out, channel_bandwidth_out;
  logic listen_enable_in, sequencer_disable_in, osc_ready_in, synth_lock_in;
  logic auto_correction_enable_in, correction_start_in, correction_auto_clear_in;
  logic low_index_correction_enable_in, temp_start_in, signal_level_threshold_in;
  logic [15:0] bit_cycles_in, amp_ramp_time_in, freq_error_sample_in, c;
  logic [15:0] freq_error_result_out, freq_correction_result_out;
  logic [7:0] low_index_offset_in, temp_adc_in, rx_start_timeout_in, threshold_timeout_in;
  logic [7:0] temp_value_out;
  logic [23:0] carrier_setting_in, carrier_out, acc;
  logic listen_active_out, osc_enable_out, synth_enable_out, tx_enable_out, rx_enable_out;
  logic amp_regulator_out, amp_ramp_out, data_clock_enable_out, synth_lock_out;
  logic correction_busy_out, correction_start_clear_out, temp_running_out;
  logic temp_start_clear_out, timeout_out, carrier_on;
  int mismatches = 0;
  int check_count = 0;
  int seed = 32'h7ee6;
  int n, t, e, cclr, tclr, touts;
  ////////////////////////////////////////
  tms_radio_model u_radio (.clock_in, .reset_in, .osc_enable_in(osc_enable_out),
    .synth_enable_in(synth_enable_out), .carrier_on_in(carrier_on),
    .osc_ready_out(osc_ready_in), .synth_lock_out(synth_lock_in),
    .signal_level_out(signal_level_threshold_in));
  tms_sequencer u_dut (.clock_in, .reset_in, .mode_in, .listen_enable_in,
    .sequencer_disable_in, .bit_cycles_in, .amp_ramp_time_in, .osc_ready_in,
    .synth_lock_in, .auto_correction_enable_in, .correction_start_in,
    .correction_auto_clear_in, .low_index_correction_enable_in, .low_index_offset_in,
    .freq_error_sample_in, .carrier_setting_in, .rx_bandwidth_in,
    .correction_bandwidth_in, .temp_start_in, .temp_adc_in, .rx_start_timeout_in,
    .threshold_timeout_in, .signal_level_threshold_in, .active_mode_out,
    .listen_active_out, .osc_enable_out, .synth_enable_out, .tx_enable_out,
    .rx_enable_out, .amp_regulator_out, .amp_ramp_out, .data_clock_enable_out,
    .synth_lock_out, .freq_error_result_out, .freq_correction_result_out, .carrier_out,
    .channel_bandwidth_out, .correction_busy_out, .correction_start_clear_out,
    .temp_running_out, .temp_start_clear_out, .temp_value_out, .timeout_out);
  always #50 clock_in = ~clock_in;
  // one-cycle pulses are counted here so no scenario can miss one
  always @(posedge clock_in) begin
    cclr += (correction_start_clear_out === 1'b1);
    tclr += (temp_start_clear_out === 1'b1);
    touts += (timeout_out === 1'b1);
  end
  ////////////////////////////////////////
  task automatic tick(input int k);
    repeat (k) @(posedge clock_in);
    #10;
  endtask
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_lv(ref logic s, input logic lv, input int lim);
    n = 0;
    while (s !== lv && n < lim) begin
      tick(1);
      n++;
    end
    if (s !== lv) mismatches++;
  endtask
  task automatic wait_int(ref int cnt, input int v, input int lim);
    n = 0;
    while (cnt == v && n < lim) begin
      tick(1);
      n++;
    end
    if (cnt == v) mismatches++;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    mismatches++;
    tally_and_finish();
  end
  ////////////////////////////////////////
  initial begin
    {mode_in, listen_enable_in, sequencer_disable_in, auto_correction_enable_in,
      correction_start_in, correction_auto_clear_in, low_index_correction_enable_in,
      temp_start_in, low_index_offset_in, temp_adc_in, freq_error_sample_in,
      carrier_setting_in, rx_start_timeout_in, threshold_timeout_in, carrier_on} = '0;
    bit_cycles_in = 16'h0008;
    amp_ramp_time_in = 16'h0008;
    rx_bandwidth_in = 3'h2;
    correction_bandwidth_in = 3'h5;
    repeat (4) @(posedge clock_in);
    #10 reset_in = 1'b0;
    check("reset mode", active_mode_out, 0);
    check("reset fei", freq_error_result_out, 0);
    sequencer_disable_in = 1'b1;
    for (int m = 0; m < 5; m++) begin
      mode_in = m[2:0];
      tick(4);
      check("mode", active_mode_out, m);
      check("synth", synth_enable_out, m >= 2);
      check("tx", tx_enable_out, m == 3);
      check("rx", rx_enable_out, m == 4);
      if (m < 2) check("osc", osc_enable_out, m == 1);
    end
    listen_enable_in = 1'b1;
    tick(4);
    check("listen", listen_active_out, 1);
    listen_enable_in = 1'b0;
    mode_in = 3'h0;
    tick(4);
    sequencer_disable_in = 1'b0;
    tick(4);
    // sequenced sleep to transmit with random bit and ramp times
    bit_cycles_in = 16'h0008 + 16'($random(seed) & 15) * 16'h0002;
    amp_ramp_time_in = 16'h0004 * (16'h0001 + 16'($random(seed) & 7));
    mode_in = 3'h3;
    wait_lv(osc_enable_out, 1'b1, 50);
    check("synth early", synth_enable_out, 0);
    wait_lv(synth_enable_out, 1'b1, 100);
    check("osc ready", osc_ready_in, 1);
    wait_lv(synth_lock_in, 1'b1, 100);
    wait_lv(synth_lock_out, 1'b1, 10);
    check("lock lag", n >= 1 && n <= 3, 1);
    wait_lv(amp_regulator_out, 1'b1, 20);
    check("lock held", synth_lock_out, 1);
    check("data_clock_out early", data_clock_enable_out, 0);
    wait_lv(amp_ramp_out, 1'b1, 200);
    t = n;
    check("ramp data_clock_out", data_clock_enable_out, 0);
    wait_lv(data_clock_enable_out, 1'b1, 200);
    e = `TMS_DIGITAL_CYCLES + 4 + bit_cycles_in / 2 + amp_ramp_time_in * 5 / 4;
    check("tx delay", t + n >= e - 2 && t + n <= e + 2, 1);
    check("tx mode", active_mode_out, 3);
    // temperature refused in sleep, then taken in standby and synthesizer
    mode_in = 3'h0;
    tick(20);
    temp_start_in = 1'b1;
    tick(10);
    check("temp sleep", tclr, 0);
    check("temp idle", temp_running_out, 0);
    temp_start_in = 1'b0;
    for (int m = 1; m < 3; m++) begin
      mode_in = m[2:0];
      tick(60);
      temp_adc_in = 8'($random(seed));
      t = tclr;
      temp_start_in = 1'b1;
      wait_int(tclr, t, 10);
      tick(3);
      temp_start_in = 1'b0;
      check("temp once", tclr, t + 1);
      check("temp run", temp_running_out, 1);
      wait_lv(temp_running_out, 1'b0, 1000);
      check("temp time", n + 4 < `TMS_TEMP_CYCLES, 1);
      check("temp value", temp_value_out, 8'hff - temp_adc_in);
    end
    // receive timeouts: 2 x 16 bits of 4 clocks, then 1 x 16 bits after the level flag
    bit_cycles_in = 16'h0004;
    rx_start_timeout_in = 8'h02;
    threshold_timeout_in = 8'h01;
    mode_in = 3'h4;
    wait_lv(rx_enable_out, 1'b1, 100);
    t = touts;
    wait_int(touts, t, 200);
    check("start timeout", n >= 126 && n <= 131, 1);
    carrier_on = 1'b1;
    t = touts;
    wait_int(touts, t, 200);
    check("level timeout", n >= 62 && n <= 70, 1);
    // host-started corrections while preamble is on air
    carrier_setting_in = 24'($random(seed));
    acc = 24'h0;
    for (int k = 0; k < 4; k++) begin
      low_index_correction_enable_in = k[0];
      low_index_offset_in = 8'($random(seed) | 4);
      freq_error_sample_in = 16'($random(seed));
      t = cclr;
      correction_start_in = 1'b1;
      wait_int(cclr, t, 10);
      tick(2);
      check("afc bw", channel_bandwidth_out, correction_bandwidth_in);
      correction_start_in = 1'b0;
      wait_lv(correction_busy_out, 1'b0, 200);
      check("eval time", n + 2 >= 15 && n + 2 <= 17, 1);
      c = freq_error_sample_in + (k[0] ? 16'(low_index_offset_in) : 16'h0000);
      acc = acc + {{8{c[15]}}, c};
      check("fei", freq_error_result_out, freq_error_sample_in);
      check("corr", freq_correction_result_out, c);
      check("carrier", carrier_out, carrier_setting_in - acc);
      check("rx bw", channel_bandwidth_out, rx_bandwidth_in);
      check("one take", cclr, t + 1);
    end
    // automatic correction at each receive entry, cleared then kept
    auto_correction_enable_in = 1'b1;
    low_index_correction_enable_in = 1'b0;
    for (int k = 0; k < 2; k++) begin
      correction_auto_clear_in = !k[0];
      freq_error_sample_in = 16'($random(seed));
      mode_in = 3'h2;
      tick(10);
      mode_in = 3'h4;
      wait_lv(correction_busy_out, 1'b1, 100);
      check("auto start", correction_busy_out, 1);
      wait_lv(correction_busy_out, 1'b0, 100);
      // auto clear gives back only the last correction; older ones stay in the carrier
      if (k == 0) acc = acc - {{8{c[15]}}, c};
      c = freq_error_sample_in;
      acc = acc + {{8{c[15]}}, c};
      check("auto carrier", carrier_out, carrier_setting_in - acc);
    end
    tally_and_finish();
  end
endmodule
